// [rtl/mudc_defines.svh]
// register offsets, field positions, limits and timing counts of the delay controller
`ifndef MUDC_DEFINES_SVH
`define MUDC_DEFINES_SVH

`define MUDC_OFF_IEN    8'h03
`define MUDC_OFF_STAT   8'h04
`define MUDC_OFF_POL    8'h2F
`define MUDC_OFF_DCC    8'h30
`define MUDC_OFF_CTL    8'h33
`define MUDC_OFF_LOW    8'h39
`define MUDC_OFF_UPR    8'h3A
`define MUDC_OFF_BST    8'h3E

`define MUDC_CTL_EN     0
`define MUDC_CTL_SAMP   3
`define MUDC_CTL_MODE   4
`define MUDC_CTL_SLOPE  6
`define MUDC_POL_MARGIN 0
`define MUDC_POL_FAIL   5
`define MUDC_POL_TOL    7
`define MUDC_LOW_TGT    0
`define MUDC_LOW_DIR    5
`define MUDC_LOW_LSB    7
`define MUDC_DCC_EN     7
`define MUDC_BST_EN     5
`define MUDC_STAT_ACQ   3
`define MUDC_STAT_LOST  2

`define MUDC_RST_BYTE   8'h00
`define MUDC_DLY_MAX    9'h1AF
`define MUDC_PH_MAX     5'h10
`define MUDC_SLOPE_MOVE 5'h02
`define MUDC_TOL_LOOSE  5'h02
`define MUDC_DRIFT_MAX  5'h05

`define MUDC_CLK_MHZ    125
`define MUDC_SETTLE_NS  64
`define MUDC_SETTLE_CYC ((`MUDC_SETTLE_NS * `MUDC_CLK_MHZ + 999) / 1000)
`define MUDC_LOCK_TYP_CYC 180000

`endif

// [rtl/mudc_pkg.sv]
// types shared by the delay controller files
package mudc_pkg;
    typedef enum logic [5:0] {
        MUDC_IDLE   = 6'h01,
        MUDC_SEARCH = 6'h02,
        MUDC_SLP_UP = 6'h04,
        MUDC_SLP_DN = 6'h08,
        MUDC_TRACK  = 6'h10,
        MUDC_HOLD   = 6'h20
    } mudc_state_e;
    typedef logic [1:0] mudc_side_t;
endpackage : mudc_pkg

// [rtl/mudc_phase_sampler.sv]
// comparator phase synchroniser and settle timer, one sample every SETTLE_CYC cycles while the delay holds
`timescale 1ns/1ps
`include "mudc_defines.svh"
module mudc_phase_sampler #(
    parameter int SETTLE_CYC = `MUDC_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    // delay currently driven to the line
    input  wire logic [8:0] delay_in,
    // raw comparator phase, asynchronous
    input  wire logic [4:0] phase_in,
    // settled sample
    output logic      [4:0] phase_out,
    output logic            valid_out
);
    localparam logic [7:0] LAST = 8'(SETTLE_CYC - 1);

    logic [4:0] sync1_q;
    logic [4:0] sync2_q;
    logic [8:0] dly_last_q;
    logic [7:0] cnt_q;
    logic       vld_q;

    // any delay change restarts the settle wait
    wire restart = delay_in != dly_last_q;
    wire expire  = !restart && cnt_q == LAST;
    // a sample that lands as the delay moves belongs to the old delay: hold it back
    assign valid_out = vld_q && !restart;

    // two-stage synchroniser, first stage read only by second
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end
        else
        begin
            sync1_q <= phase_in;
            sync2_q <= sync1_q;
        end
    end

    // settle counter and sample register
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            dly_last_q <= 9'h000;
            cnt_q      <= 8'h00;
            phase_out  <= 5'h00;
            vld_q      <= 1'b0;
        end
        else
        begin
            dly_last_q <= delay_in;
            cnt_q      <= (restart || expire) ? 8'h00 : cnt_q + 8'h01;
            vld_q      <= expire;
            if (expire)
                phase_out <= sync2_q;
        end
    end
endmodule : mudc_phase_sampler

// [rtl/mudc_ctrl.sv]
// delay-line phase controller: registers, search, slope check, tracking, lock status
// What this block does
// - setting the enable bit starts the controller in phase search, or in tracking in mode 01.
// - mode 00 search then track, 01 track only, 10 search only.
// - start delay is nine bits, LSB low register bit 7; above 431 disallowed.
// - search until phase equals target; targets above 16 never lock.
// - on target phase, check slope against desired slope; both must match.
// - tolerance bit 0 accepts within two codes, 1 needs exact target.
// - direction 00 down only, 01 up only, 10 alternating.
// - alternating steps both ways until a margin is hit, then the other only.
// - margin hit on second side too: resume alternating inside the margins.
// - reaching a line endpoint in direction 00 or 01 fails; action bit 0 keeps searching, 1 resets.
// - slope probe goes up then down until phase moves 2 or limits.
// - slope valid when up and down phases straddle target in desired order.
// - tracking steps delay by +1, -1 or 0 using desired slope only.
// - locked, tracking and drifting over five codes clears acquired, sets dropped.
// - after loss, keep tracking or restart search as configured.
// - rising capture strobe latches current delay and phase for readback.
// - lock typically reached within 180000 cycles of enabling.
// - manual mode sets the delay from the start value directly; holding the strobe high captures nothing.
// - status bits clear by writing one to their position; drift also clears acquired.
// - each status bit gated by its enable bit onto one interrupt output.
`timescale 1ns/1ps
`include "mudc_defines.svh"
module mudc_ctrl #(
    parameter int TYP_LOCK_CYC = `MUDC_LOCK_TYP_CYC,
    parameter int SETTLE_CYC   = `MUDC_SETTLE_CYC
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       resetn_in,
    // register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // comparator and delay line
    input  wire logic [4:0] phase_meas_in,
    output logic      [8:0] delay_line_value_out,
    output logic            dcc_en_out,
    output logic            comp_boost_out,
    // status
    output logic            lock_irq_out,
    output logic            lock_late_out
);
    localparam int LKW = $clog2(TYP_LOCK_CYC + 1);

    logic [7:0] pol_q, dcc_q, ctl_q, low_q, upr_q, bst_q, ien_q;
    logic       lock_acquired_q, lock_dropped_q, cap_sel_q;
    logic [8:0] dly_q, dly_d, up_q, up_d, dn_q, dn_d, cand_q, cand_d, cap_dly_q;
    logic [4:0] p0_q, p0_d, pup_q, pup_d, cap_ph_q;
    logic       turn_q, turn_d, set_acq, set_lost;
    logic [LKW-1:0] lk_cnt_q;
    mudc_pkg::mudc_side_t  side_q, side_d;
    mudc_pkg::mudc_state_e st_q, st_d;
    logic [8:0] s_dly, s_up, s_dn;
    logic       s_turn, s_fail, go_up;
    mudc_pkg::mudc_side_t  s_side;
    logic [4:0] smp_ph;
    logic       smp_vld;

    // register write decode
    wire wr_ien  = reg_wr_in && reg_addr_in == `MUDC_OFF_IEN;
    wire wr_stat = reg_wr_in && reg_addr_in == `MUDC_OFF_STAT;
    wire wr_pol  = reg_wr_in && reg_addr_in == `MUDC_OFF_POL;
    wire wr_dcc  = reg_wr_in && reg_addr_in == `MUDC_OFF_DCC;
    wire wr_ctl  = reg_wr_in && reg_addr_in == `MUDC_OFF_CTL;
    wire wr_low  = reg_wr_in && reg_addr_in == `MUDC_OFF_LOW;
    wire wr_upr  = reg_wr_in && reg_addr_in == `MUDC_OFF_UPR;
    wire wr_bst  = reg_wr_in && reg_addr_in == `MUDC_OFF_BST;
    // capture on low-to-high write of the strobe bit only
    wire samp_rise = wr_ctl && reg_wdata_in[`MUDC_CTL_SAMP] && !ctl_q[`MUDC_CTL_SAMP];

    // configuration fields
    wire       en       = ctl_q[`MUDC_CTL_EN];
    wire [1:0] mode     = ctl_q[`MUDC_CTL_MODE +: 2];
    wire       slope    = ctl_q[`MUDC_CTL_SLOPE];
    wire       tol      = pol_q[`MUDC_POL_TOL];
    wire       fail_rst = pol_q[`MUDC_POL_FAIL];
    wire [4:0] margin   = pol_q[`MUDC_POL_MARGIN +: 5];
    wire [1:0] dir      = low_q[`MUDC_LOW_DIR +: 2];
    wire [4:0] tgt      = low_q[`MUDC_LOW_TGT +: 5];
    wire [8:0] start_raw = {upr_q, low_q[`MUDC_LOW_LSB]};
    wire [8:0] start_v  = (start_raw > `MUDC_DLY_MAX) ? `MUDC_DLY_MAX : start_raw;
    wire [8:0] hi_b     = `MUDC_DLY_MAX - {4'h0, margin};
    wire [8:0] lo_b     = {4'h0, margin};

    // phase comparisons on the settled sample
    wire [4:0] diff   = (smp_ph > tgt) ? smp_ph - tgt : tgt - smp_ph;
    wire [4:0] pmove  = (smp_ph > p0_q) ? smp_ph - p0_q : p0_q - smp_ph;
    wire match = (tgt <= `MUDC_PH_MAX) && (tol ? diff == 5'h00 : diff <= `MUDC_TOL_LOOSE);
    wire drift = lock_acquired_q && diff > `MUDC_DRIFT_MAX;
    wire ph_lim = pmove >= `MUDC_SLOPE_MOVE || smp_ph == `MUDC_PH_MAX || smp_ph == 5'h00;
    wire stop_up = ph_lim || dly_q == `MUDC_DLY_MAX;
    wire stop_dn = ph_lim || dly_q == 9'h000;
    wire slope_ok = (tgt <= `MUDC_PH_MAX) &&
        (slope ? (pup_q > tgt && smp_ph < tgt) : (pup_q < tgt && smp_ph > tgt));
    wire trk_only = mode == 2'h1;
    wire srch_only = mode == 2'h2;
    wire st_idle = st_q == mudc_pkg::MUDC_IDLE;
    wire st_trk  = st_q == mudc_pkg::MUDC_TRACK;

    // settled sampling of the comparator
    mudc_phase_sampler #(.SETTLE_CYC(SETTLE_CYC)) u_smp (
        .ref_clk_in (ref_clk_in),
        .resetn_in  (resetn_in),
        .delay_in   (dly_q),
        .phase_in   (phase_meas_in),
        .phase_out  (smp_ph),
        .valid_out  (smp_vld)
    );

    // next search position from the sweep pointers
    always_comb
    begin
        s_up   = up_q;
        s_dn   = dn_q;
        s_dly  = dly_q;
        s_turn = turn_q;
        s_side = side_q;
        s_fail = 1'b0;
        go_up  = 1'b0;
        unique case (dir)
            2'h0:
            begin
                s_fail = dn_q == 9'h000;
                s_dn   = s_fail ? dn_q : dn_q - 9'h001;
                s_dly  = s_dn;
            end
            2'h1:
            begin
                s_fail = up_q == `MUDC_DLY_MAX;
                s_up   = s_fail ? up_q : up_q + 9'h001;
                s_dly  = s_up;
            end
            default:
            begin
                go_up = (side_q == 2'h0) ? turn_q : side_q == 2'h1;
                if (go_up && up_q < hi_b)
                begin
                    s_up   = up_q + 9'h001;
                    s_dly  = s_up;
                    s_turn = 1'b0;
                end
                else if (!go_up && dn_q > lo_b)
                begin
                    s_dn   = dn_q - 9'h001;
                    s_dly  = s_dn;
                    s_turn = 1'b1;
                end
                else if (side_q == 2'h0)
                    s_side = go_up ? 2'h2 : 2'h1;
                else
                begin
                    s_side = 2'h0;
                    s_up   = start_v;
                    s_dn   = start_v;
                    s_dly  = start_v;
                    s_turn = 1'b1;
                end
            end
        endcase
    end

    // controller state machine, acting once per settled sample outside idle
    always_comb
    begin
        st_d = st_q; dly_d = dly_q; up_d = up_q; dn_d = dn_q;
        turn_d = turn_q; side_d = side_q; cand_d = cand_q;
        p0_d = p0_q; pup_d = pup_q; set_acq = 1'b0; set_lost = 1'b0;
        unique case (st_q)
            mudc_pkg::MUDC_IDLE:
            begin
                dly_d = start_v; up_d = start_v; dn_d = start_v;
                turn_d = 1'b1; side_d = 2'h0;
                if (en)
                    st_d = trk_only ? mudc_pkg::MUDC_TRACK : mudc_pkg::MUDC_SEARCH;
            end
            mudc_pkg::MUDC_SEARCH:
                if (smp_vld && match)
                begin
                    cand_d = dly_q; p0_d = smp_ph; st_d = mudc_pkg::MUDC_SLP_UP;
                end
                else if (smp_vld && s_fail && fail_rst)
                    st_d = mudc_pkg::MUDC_IDLE;
                else if (smp_vld && s_fail)
                begin
                    dly_d = start_v; up_d = start_v; dn_d = start_v;
                end
                else if (smp_vld)
                begin
                    dly_d = s_dly; up_d = s_up; dn_d = s_dn;
                    turn_d = s_turn; side_d = s_side;
                end
            mudc_pkg::MUDC_SLP_UP:
                if (smp_vld && stop_up)
                begin
                    pup_d = smp_ph; dly_d = cand_q; st_d = mudc_pkg::MUDC_SLP_DN;
                end
                else if (smp_vld)
                    dly_d = dly_q + 9'h001;
            mudc_pkg::MUDC_SLP_DN:
                if (smp_vld && stop_dn && slope_ok)
                begin
                    dly_d = cand_q; set_acq = 1'b1;
                    st_d = srch_only ? mudc_pkg::MUDC_HOLD : mudc_pkg::MUDC_TRACK;
                end
                else if (smp_vld && stop_dn)
                begin
                    st_d = mudc_pkg::MUDC_SEARCH; dly_d = s_dly; up_d = s_up;
                    dn_d = s_dn; turn_d = s_turn; side_d = s_side;
                end
                else if (smp_vld)
                    dly_d = dly_q - 9'h001;
            mudc_pkg::MUDC_TRACK:
                if (smp_vld && drift)
                begin
                    set_lost = 1'b1;
                    if (fail_rst && !trk_only)
                        st_d = mudc_pkg::MUDC_IDLE;
                end
                else if (smp_vld)
                begin
                    set_acq = !lock_acquired_q && match;
                    if ((smp_ph < tgt) == slope && smp_ph != tgt && dly_q != `MUDC_DLY_MAX)
                        dly_d = dly_q + 9'h001;
                    else if (smp_ph != tgt && (smp_ph < tgt) != slope && dly_q != 9'h000)
                        dly_d = dly_q - 9'h001;
                end
            mudc_pkg::MUDC_HOLD:
                st_d = st_q;
            default:
                st_d = mudc_pkg::MUDC_IDLE;
        endcase
        if (!en)
            st_d = mudc_pkg::MUDC_IDLE;
    end

    // controller state registers
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            st_q <= mudc_pkg::MUDC_IDLE; dly_q <= 9'h000; up_q <= 9'h000;
            dn_q <= 9'h000; cand_q <= 9'h000; turn_q <= 1'b1;
            side_q <= 2'h0; p0_q <= 5'h00; pup_q <= 5'h00;
        end
        else
        begin
            st_q <= st_d; dly_q <= dly_d; up_q <= up_d;
            dn_q <= dn_d; cand_q <= cand_d; turn_q <= turn_d;
            side_q <= side_d; p0_q <= p0_d; pup_q <= pup_d;
        end
    end

    // software-visible configuration registers
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            pol_q <= `MUDC_RST_BYTE; dcc_q <= `MUDC_RST_BYTE; ctl_q <= `MUDC_RST_BYTE;
            low_q <= `MUDC_RST_BYTE; upr_q <= `MUDC_RST_BYTE; bst_q <= `MUDC_RST_BYTE;
            ien_q <= `MUDC_RST_BYTE;
        end
        else
        begin
            if (wr_pol) pol_q <= reg_wdata_in;
            if (wr_dcc) dcc_q <= reg_wdata_in;
            if (wr_ctl) ctl_q <= reg_wdata_in;
            if (wr_low) low_q <= reg_wdata_in;
            if (wr_upr) upr_q <= reg_wdata_in;
            if (wr_bst) bst_q <= reg_wdata_in;
            if (wr_ien) ien_q <= reg_wdata_in;
        end
    end

    // lock flags: hardware set wins over write-one-to-clear
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            lock_acquired_q <= 1'b0;
            lock_dropped_q  <= 1'b0;
        end
        else
        begin
            if (set_acq)
                lock_acquired_q <= 1'b1;
            else if (set_lost || (wr_stat && reg_wdata_in[`MUDC_STAT_ACQ]))
                lock_acquired_q <= 1'b0;
            if (set_lost)
                lock_dropped_q <= 1'b1;
            else if (wr_stat && reg_wdata_in[`MUDC_STAT_LOST])
                lock_dropped_q <= 1'b0;
        end
    end

    // capture of current delay and phase, readback select
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cap_dly_q <= 9'h000; cap_ph_q <= 5'h00; cap_sel_q <= 1'b0;
        end
        else if (samp_rise)
        begin
            cap_dly_q <= dly_q; cap_ph_q <= smp_ph; cap_sel_q <= 1'b1;
        end
        else if (wr_low || wr_upr)
            cap_sel_q <= 1'b0;
    end

    // readback selection
    wire [7:0] low_rd  = cap_sel_q ? {cap_dly_q[0], low_q[6:5], cap_ph_q} : low_q;
    wire [7:0] upr_rd  = cap_sel_q ? cap_dly_q[8:1] : upr_q;
    wire [7:0] stat_rd = {4'h0, lock_acquired_q, lock_dropped_q, 2'h0};
    wire [7:0] rd_mux  =
        (reg_addr_in == `MUDC_OFF_IEN)  ? ien_q  :
        (reg_addr_in == `MUDC_OFF_STAT) ? stat_rd :
        (reg_addr_in == `MUDC_OFF_POL)  ? pol_q  :
        (reg_addr_in == `MUDC_OFF_DCC)  ? dcc_q  :
        (reg_addr_in == `MUDC_OFF_CTL)  ? ctl_q  :
        (reg_addr_in == `MUDC_OFF_LOW)  ? low_rd :
        (reg_addr_in == `MUDC_OFF_UPR)  ? upr_rd :
        (reg_addr_in == `MUDC_OFF_BST)  ? bst_q  : 8'h00;
    wire irq_d = (lock_acquired_q && ien_q[`MUDC_STAT_ACQ]) ||
                 (lock_dropped_q && ien_q[`MUDC_STAT_LOST]);
    wire lk_run = !st_idle && !lock_acquired_q && lk_cnt_q != LKW'(TYP_LOCK_CYC);

    // read data, interrupt and lock-time watchdog registers
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            reg_rdata_out <= 8'h00; lock_irq_out <= 1'b0; lk_cnt_q <= '0;
        end
        else
        begin
            if (reg_rd_in) reg_rdata_out <= rd_mux;
            lock_irq_out <= irq_d;
            lk_cnt_q <= st_idle ? '0 : lk_cnt_q + LKW'(lk_run);
        end
    end

    // pin-level outputs
    assign delay_line_value_out = dly_q;
    assign dcc_en_out     = dcc_q[`MUDC_DCC_EN];
    assign comp_boost_out = bst_q[`MUDC_BST_EN];
    assign lock_late_out  = !lock_acquired_q && lk_cnt_q == LKW'(TYP_LOCK_CYC);

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    a_delay_in_range: assert property (dly_q <= `MUDC_DLY_MAX)
        else $error("delay outside 0..431");
    a_enable_starts: assert property (st_idle && en && !trk_only |=> st_q == mudc_pkg::MUDC_SEARCH)
        else $error("enable did not start search");
    a_track_only_mode: assert property (st_idle && en && trk_only |=> st_trk)
        else $error("track-only mode skipped track");
    a_bad_target: assert property (tgt > `MUDC_PH_MAX && $stable(tgt) |=> !$rose(lock_acquired_q))
        else $error("lock with illegal target");
    a_track_step: assert property (st_trk && smp_vld && !drift && en |=>
        (dly_q - $past(dly_q) <= 9'h001) || ($past(dly_q) - dly_q <= 9'h001))
        else $error("tracking step larger than one");
    a_drift_loses: assert property (st_trk && smp_vld && drift |=>
        lock_dropped_q && !lock_acquired_q)
        else $error("drift did not drop lock");
    a_w1c_clear: assert property (wr_stat && reg_wdata_in[`MUDC_STAT_LOST] && !set_lost |=>
        !lock_dropped_q)
        else $error("dropped flag not cleared");
    a_capture_delay: assert property (samp_rise |=> cap_sel_q && cap_dly_q == $past(dly_q))
        else $error("capture missed delay");
    a_delay_on_sample: assert property ($changed(dly_q) |-> $past(smp_vld || st_idle))
        else $error("delay moved without a sample");
    a_irq_gate: assert property (irq_d |=> lock_irq_out)
        else $error("enabled flag missed irq");

    c_lock: cover property (st_q == mudc_pkg::MUDC_SLP_DN ##1 lock_acquired_q);
    c_lost: cover property ($rose(lock_dropped_q));
    c_capture: cover property (samp_rise ##1 reg_rd_in && reg_addr_in == `MUDC_OFF_LOW);
    c_fail: cover property (st_q == mudc_pkg::MUDC_SEARCH && smp_vld && s_fail);
endmodule : mudc_ctrl

// [tb/mudc_phase_model.sv]
// behavioural phase comparator: phase seen for each delay line value
`timescale 1ns/1ps
module mudc_phase_model (
    // delay line setting from the controller
    input  wire logic [8:0] delay_in,
    // measured phase, 0 to 16, rising with delay
    output logic      [4:0] phase_out
);
    // four delay codes per phase code, wrapping after 16
    assign phase_out = 5'((delay_in >> 2) % 17);
endmodule : mudc_phase_model

// [tb/tb_top.sv]
// self-checking bench for the delay-line phase controller
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk_in           = 1'b0;
    logic        resetn_in            = 1'b0;
    logic [7:0]  reg_addr_in          = 8'h00;
    logic [7:0]  reg_wdata_in         = 8'h00;
    logic        reg_wr_in            = 1'b0;
    logic        reg_rd_in            = 1'b0;
    logic [7:0]  reg_rdata_out;
    logic [4:0]  phase_meas_in;
    logic [8:0]  delay_line_value_out;
    logic        dcc_en_out;
    logic        comp_boost_out;
    logic        lock_irq_out;
    logic        lock_late_out;
    logic [7:0]  d;
    logic [7:0]  e;
    int          errors               = 0;
    int          checks               = 0;
    // address, write data, expected readback
    logic [23:0] rows [5]             = '{24'h2FCECE, 24'h308080, 24'h3E3838,
                                          24'h030C0C, 24'h55AA00};

    // clock at 125 MHz
    always #4 ref_clk_in = ~ref_clk_in;

    mudc_ctrl #(.TYP_LOCK_CYC(200), .SETTLE_CYC(2)) uut (
        .ref_clk_in           (ref_clk_in),
        .resetn_in            (resetn_in),
        .reg_addr_in          (reg_addr_in),
        .reg_wdata_in         (reg_wdata_in),
        .reg_wr_in            (reg_wr_in),
        .reg_rd_in            (reg_rd_in),
        .reg_rdata_out        (reg_rdata_out),
        .phase_meas_in        (phase_meas_in),
        .delay_line_value_out (delay_line_value_out),
        .dcc_en_out           (dcc_en_out),
        .comp_boost_out       (comp_boost_out),
        .lock_irq_out         (lock_irq_out),
        .lock_late_out        (lock_late_out)
    );

    mudc_phase_model u_model (
        .delay_in  (delay_line_value_out),
        .phase_out (phase_meas_in)
    );

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b0;
        @(negedge ref_clk_in);
        v = reg_rdata_out;
    endtask : rd

    task check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task final_report;
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        // reset values, readback, unmapped place
        foreach (rows[i])
        begin
            rd(rows[i][23:16], d);
            check(d, 9'h000);
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], d);
            check(d, rows[i][7:0]);
        end
        check(dcc_en_out, 9'h001);
        check(comp_boost_out, 9'h001);
        // manual mode: delay 100 gives phase 8
        wr(8'h39, 8'h00);
        wr(8'h3A, 8'h32);
        repeat (20) @(posedge ref_clk_in);
        check(delay_line_value_out, 9'd100);
        wr(8'h33, 8'h08);
        rd(8'h39, d);
        check(d[4:0], 9'h008);
        rd(8'h3A, e);
        check({e, d[7]}, 9'd100);
        // start value above the line end is held at 431
        wr(8'h3A, 8'hFF);
        wr(8'h39, 8'h80);
        repeat (4) @(posedge ref_clk_in);
        check(delay_line_value_out, 9'h1AF);
        // strobe held high: a second write with the bit set captures nothing
        wr(8'h33, 8'h08);
        rd(8'h3A, e);
        check(e, 9'h0FF);
        // documented start-up: slope up, target 14, start 216, alternating
        wr(8'h33, 8'h42);
        wr(8'h39, 8'h4E);
        wr(8'h3A, 8'h6C);
        wr(8'h03, 8'h00);
        wr(8'h04, 8'hFE);
        wr(8'h03, 8'h0C);
        wr(8'h33, 8'h43);
        d = 8'h00;
        for (int n = 0; n < 2000 && d !== 8'h08; n++)
            rd(8'h04, d);
        check(d, 9'h008);
        check(lock_late_out, 9'h000);
        check(delay_line_value_out, 9'd195);
        check(lock_irq_out, 9'h001);
        check(phase_meas_in, 9'h00E);
        // writing zeros leaves status alone
        wr(8'h04, 8'h00);
        rd(8'h04, d);
        check(d, 9'h008);
        // capture of the locked point
        wr(8'h33, 8'h4B);
        rd(8'h39, d);
        check(d[4:0], 9'h00E);
        rd(8'h3A, e);
        check({e, d[7]}, 9'd195);
        // target moved six codes away: lock drops, tracking walks down to phase 8
        wr(8'h39, 8'hC8);
        d = 8'h00;
        for (int n = 0; n < 100 && d[2] !== 1'b1; n++)
            rd(8'h04, d);
        check(d, 9'h004);
        check(lock_irq_out, 9'h001);
        for (int n = 0; n < 200 && d !== 8'h0C; n++)
            rd(8'h04, d);
        check(d, 9'h00C);
        check(delay_line_value_out, 9'd171);
        wr(8'h04, 8'h04);
        rd(8'h04, d);
        check(d, 9'h008);
        // illegal target, down only from 8, controller reset on failure
        wr(8'h33, 8'h42);
        wr(8'h2F, 8'hEE);
        wr(8'h3A, 8'h04);
        wr(8'h39, 8'h11);
        wr(8'h04, 8'h0C);
        wr(8'h33, 8'h43);
        for (int n = 0; n < 400 && delay_line_value_out !== 9'h000; n++)
            @(negedge ref_clk_in);
        repeat (6) @(negedge ref_clk_in);
        check(delay_line_value_out, 9'd8);
        // keep searching on failure: no lock, watchdog runs out
        wr(8'h2F, 8'hCE);
        repeat (250) @(negedge ref_clk_in);
        check(lock_late_out, 9'h001);
        rd(8'h04, d);
        check(d, 9'h000);
        // track only from 216: climbs to the first phase 14 at 260
        wr(8'h33, 8'h42);
        wr(8'h39, 8'h4E);
        wr(8'h3A, 8'h6C);
        wr(8'h33, 8'h53);
        d = 8'h00;
        for (int n = 0; n < 500 && d !== 8'h08; n++)
            rd(8'h04, d);
        check(d, 9'h008);
        check(delay_line_value_out, 9'd260);
        final_report;
    end
endmodule : tb_top
